// File: rtl/acc_top.sv
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
module acc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        comparator_raw,
	input  wire logic        converter_enable,
	input  wire logic [4:0]  converter_channel_select,
	input  wire logic [1:0]  reference_selection,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_vector_ack,
	input  wire logic        positive_pin_raw,
	input  wire logic        negative_pin_raw,
	output logic             external_ref_input_enable,
	output logic             internal_ref_output_enable,
	output logic             ref_output_is_2v56,
	output logic             current_source_enable,
	output logic             comparator_power_down,
	output logic             positive_from_mux,
	output logic      [4:0]  positive_mux_channel,
	output logic             negative_from_internal,
	output logic      [2:0]  negative_ref_code,
	output logic             comparator_irq,
	output logic             capture_input,
	output logic             positive_pin_digital,
	output logic             negative_pin_digital
);

	// ==================================================
	// register state
	logic [7:0] misc_q;
	logic [7:0] ctlb_q;
	logic [7:0] csr_q;
	logic [7:0] did_q;
	logic       flag_q;
	logic       sync1_q;
	logic       sync2_q;
	logic       prev_q;
	logic       pready_q;
	logic       pslverr_q;
	logic [31:0] prdata_q;

	// ==================================================
	// bus decode
	logic       setup;
	logic       wr_commit;
	logic       hit_misc;
	logic       hit_ctlb;
	logic       hit_csr;
	logic       hit_did;
	logic       mapped;
	logic [7:0] rd_d;

	assign setup     = psel && !penable;
	assign wr_commit = psel && penable && pready_q && pwrite;
	assign hit_misc  = (paddr == acc_pkg::OFS_MISC);
	assign hit_ctlb  = (paddr == acc_pkg::OFS_CTLB);
	assign hit_csr   = (paddr == acc_pkg::OFS_CSR);
	assign hit_did   = (paddr == acc_pkg::OFS_DID);
	assign mapped    = hit_misc || hit_ctlb || hit_csr || hit_did;

	always_comb begin
		rd_d = 8'h00;
		if (hit_misc) begin
			rd_d = misc_q;
		end else if (hit_ctlb) begin
			rd_d = ctlb_q;
		end else if (hit_csr) begin
			rd_d = {csr_q[7:6], sync2_q, flag_q, csr_q[3:0]};
		end else if (hit_did) begin
			rd_d = did_q;
		end
	end

	// ready one cycle after setup, so zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !mapped;
			prdata_q  <= (setup && !pwrite) ? {24'h00_0000, rd_d} : 32'h0000_0000;
		end
	end

	// ==================================================
	// register writes
	// reserved bits masked in misc, ctlb and csr; did stores all 8 written bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_q <= acc_pkg::RST_MISC;
		end else if (wr_commit && hit_misc) begin
			misc_q <= pwdata[7:0] & acc_pkg::MSK_MISC;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctlb_q <= acc_pkg::RST_CTLB;
		end else if (wr_commit && hit_ctlb) begin
			ctlb_q <= pwdata[7:0] & acc_pkg::MSK_CTLB;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr_q <= acc_pkg::RST_CSR;
		end else if (wr_commit && hit_csr) begin
			csr_q <= {pwdata[7:6], 2'h0, pwdata[3:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			did_q <= acc_pkg::RST_DID;
		end else if (wr_commit && hit_did) begin
			did_q <= pwdata[7:0];
		end
	end

	// ==================================================
	// comparator output path
	// raw result arrives from analog core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= comparator_raw;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sync2_q;
		end
	end

	// ==================================================
	// event detection and flag
	logic [1:0] mode;
	logic       evt;
	logic       clr;

	assign mode = {csr_q[acc_pkg::CSR_MODE_HI], csr_q[acc_pkg::CSR_MODE_LO]};

	always_comb begin
		evt = 1'b0;
		unique case (mode)
			acc_pkg::MODE_TOGGLE: begin
				evt = sync2_q ^ prev_q;
			end
			acc_pkg::MODE_RSVD: begin
				evt = 1'b0;
			end
			acc_pkg::MODE_FALLING: begin
				evt = prev_q && !sync2_q;
			end
			acc_pkg::MODE_RISING: begin
				evt = !prev_q && sync2_q;
			end
		endcase
	end

	// clear by vector or write one
	assign clr = irq_vector_ack || (wr_commit && hit_csr && pwdata[acc_pkg::CSR_FLAG]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (evt) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_irq <= 1'b0;
		end else begin
			comparator_irq <= flag_q && csr_q[acc_pkg::CSR_IRQEN] && global_irq_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_input <= 1'b0;
		end else begin
			capture_input <= csr_q[acc_pkg::CSR_CAPEN] && sync2_q;
		end
	end

	// ==================================================
	// analog input selection
	logic [2:0] nref_d;

	always_comb begin
		nref_d = acc_pkg::NREF_NONE;
		if (reference_selection == acc_pkg::REFSEL_1V1) begin
			nref_d = acc_pkg::NREF_1V1;
		end else if (reference_selection == acc_pkg::REFSEL_2V56) begin
			unique case ({ctlb_q[acc_pkg::CTLB_TAP_HI], ctlb_q[acc_pkg::CTLB_TAP_LO]})
				2'h0: nref_d = acc_pkg::NREF_2V56;
				2'h1: nref_d = acc_pkg::NREF_1V28;
				2'h2: nref_d = acc_pkg::NREF_0V64;
				2'h3: nref_d = acc_pkg::NREF_0V32;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			positive_from_mux      <= 1'b0;
			positive_mux_channel   <= 5'h00;
			negative_from_internal <= 1'b0;
			negative_ref_code      <= acc_pkg::NREF_NONE;
		end else begin
			positive_from_mux      <= ctlb_q[acc_pkg::CTLB_MUXEN] && !converter_enable;
			positive_mux_channel   <= (ctlb_q[acc_pkg::CTLB_MUXEN] && !converter_enable)
				? converter_channel_select : 5'h00;
			negative_from_internal <= csr_q[acc_pkg::CSR_IREF];
			negative_ref_code      <= csr_q[acc_pkg::CSR_IREF] ? nref_d : acc_pkg::NREF_NONE;
		end
	end

	// ==================================================
	// reference and power controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			external_ref_input_enable  <= 1'b0;
			internal_ref_output_enable <= 1'b0;
			ref_output_is_2v56         <= 1'b0;
			current_source_enable      <= 1'b0;
			comparator_power_down      <= 1'b0;
		end else begin
			external_ref_input_enable  <= misc_q[acc_pkg::MISC_EXTERNAL_REFERENCE_PIN];
			internal_ref_output_enable <= misc_q[acc_pkg::MISC_REFERENCE_OUTPUT_PIN];
			ref_output_is_2v56         <= reference_selection == acc_pkg::REFSEL_2V56;
			current_source_enable      <= misc_q[acc_pkg::MISC_ISRC];
			comparator_power_down      <= csr_q[acc_pkg::CSR_DIS];
		end
	end

	// ==================================================
	// digital input buffers
	// disabled pins read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			positive_pin_digital <= 1'b0;
			negative_pin_digital <= 1'b0;
		end else begin
			positive_pin_digital <= positive_pin_raw && !did_q[acc_pkg::DID_POS];
			negative_pin_digital <= negative_pin_raw && !did_q[acc_pkg::DID_NEG];
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ==================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_misc_reserved_zero: assert property (
		misc_q[7:3] == 5'h00)
		else $error("misc reserved bits not zero");

	chk_sync_delay: assert property (
		$rose(sync2_q) |-> $past(comparator_raw, 2))
		else $error("status not two cycles behind raw");

	chk_mux_select: assert property (
		(ctlb_q[acc_pkg::CTLB_MUXEN] && !converter_enable) |=> positive_from_mux)
		else $error("mux source not selected");

	chk_mux_off_adc: assert property (
		converter_enable |=> !positive_from_mux)
		else $error("mux source while converter on");

	chk_flag_rise: assert property (
		(mode == acc_pkg::MODE_RISING && $rose(sync2_q)) |=> flag_q)
		else $error("rising edge did not set flag");

	chk_reserved_mode: assert property (
		(mode == acc_pkg::MODE_RSVD && !flag_q && !$past(flag_q)) |=> !flag_q)
		else $error("reserved mode set flag");

	chk_flag_clear: assert property (
		(flag_q && irq_vector_ack && !evt) |=> !flag_q)
		else $error("vector did not clear flag");

	chk_irq_gate: assert property (
		comparator_irq |-> $past(flag_q) && $past(csr_q[acc_pkg::CSR_IRQEN])
			&& $past(global_irq_enable))
		else $error("request without flag and enables");

	chk_capture_off: assert property (
		!csr_q[acc_pkg::CSR_CAPEN] |=> !capture_input)
		else $error("capture driven while disabled");

	chk_power_down: assert property (
		csr_q[acc_pkg::CSR_DIS] |=> comparator_power_down)
		else $error("power down not applied");

	chk_input_disable: assert property (
		did_q[acc_pkg::DID_POS] |=> !positive_pin_digital)
		else $error("disabled pin not zero");

	chk_tap_eighth: assert property (
		(csr_q[acc_pkg::CSR_IREF] && reference_selection == acc_pkg::REFSEL_2V56
			&& ctlb_q[5:4] == 2'h3) |=> negative_ref_code == acc_pkg::NREF_0V32)
		else $error("eighth tap not selected");

	chk_flag_fall: assert property (
		(mode == acc_pkg::MODE_FALLING && $fell(sync2_q)) |=> flag_q)
		else $error("falling edge did not set flag");

	chk_flag_toggle: assert property (
		(mode == acc_pkg::MODE_TOGGLE && $changed(sync2_q)) |=> flag_q)
		else $error("toggle did not set flag");

	chk_mux_channel: assert property (
		(ctlb_q[acc_pkg::CTLB_MUXEN] && !converter_enable)
			|=> positive_mux_channel == $past(converter_channel_select))
		else $error("mux channel not passed");

	chk_ref_1v1: assert property (
		(csr_q[acc_pkg::CSR_IREF] && reference_selection == acc_pkg::REFSEL_1V1)
			|=> negative_ref_code == acc_pkg::NREF_1V1)
		else $error("1.1V reference not selected");

	chk_capture_on: assert property (
		csr_q[acc_pkg::CSR_CAPEN] |=> capture_input == $past(sync2_q))
		else $error("capture not following output");

	cov_rising_irq:  cover property ($rose(comparator_irq));
	cov_falling_set: cover property (mode == acc_pkg::MODE_FALLING && $rose(flag_q));
	cov_set_clear:   cover property (evt && clr);
	cov_unmapped:    cover property (pslverr_q && pready_q);

endmodule

// File: rtl/acc_pkg.sv
// ==================================================
// analog comparator control constants
package acc_pkg;

	// ==================================================
	// register byte offsets
	localparam logic [7:0] OFS_MISC = 8'h00;
	localparam logic [7:0] OFS_CTLB = 8'h04;
	localparam logic [7:0] OFS_CSR  = 8'h08;
	localparam logic [7:0] OFS_DID  = 8'h0C;

	// ==================================================
	// reset values
	localparam logic [7:0] RST_MISC = 8'h00;
	localparam logic [7:0] RST_CTLB = 8'h00;
	localparam logic [7:0] RST_CSR  = 8'h00;
	localparam logic [7:0] RST_DID  = 8'h00;

	// ==================================================
	// writable bit masks
	localparam logic [7:0] MSK_MISC = 8'h07;
	localparam logic [7:0] MSK_CTLB = 8'hF7;

	// ==================================================
	// field positions
	localparam int MISC_ISRC   = 0;
	localparam int MISC_REFERENCE_OUTPUT_PIN   = 1;
	localparam int MISC_EXTERNAL_REFERENCE_PIN   = 2;
	localparam int CTLB_TAP_LO = 4;
	localparam int CTLB_TAP_HI = 5;
	localparam int CTLB_MUXEN  = 6;
	localparam int CSR_MODE_LO = 0;
	localparam int CSR_MODE_HI = 1;
	localparam int CSR_CAPEN   = 2;
	localparam int CSR_IRQEN   = 3;
	localparam int CSR_FLAG    = 4;
	localparam int CSR_OUT     = 5;
	localparam int CSR_IREF    = 6;
	localparam int CSR_DIS     = 7;
	localparam int DID_NEG     = 6;
	localparam int DID_POS     = 7;

	// ==================================================
	// interrupt modes
	localparam logic [1:0] MODE_TOGGLE  = 2'h0;
	localparam logic [1:0] MODE_RSVD    = 2'h1;
	localparam logic [1:0] MODE_FALLING = 2'h2;
	localparam logic [1:0] MODE_RISING  = 2'h3;

	// ==================================================
	// reference selection codes
	localparam logic [1:0] REFSEL_1V1  = 2'h1;
	localparam logic [1:0] REFSEL_2V56 = 2'h3;

	// ==================================================
	// negative input reference codes
	localparam logic [2:0] NREF_NONE  = 3'h0;
	localparam logic [2:0] NREF_1V1   = 3'h1;
	localparam logic [2:0] NREF_2V56  = 3'h2;
	localparam logic [2:0] NREF_1V28  = 3'h3;
	localparam logic [2:0] NREF_0V64  = 3'h4;
	localparam logic [2:0] NREF_0V32  = 3'h5;

endpackage

// File: verif/tb_acc_top.sv
`timescale 1ns/10ps
module tb_acc_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic        comparator_raw, converter_enable, global_irq_enable, irq_vector_ack;
	logic [4:0]  converter_channel_select, positive_mux_channel;
	logic [1:0]  reference_selection, m;
	logic        positive_pin_raw, negative_pin_raw, positive_pin_digital;
	logic        negative_pin_digital, external_ref_input_enable, internal_ref_output_enable;
	logic        ref_output_is_2v56, current_source_enable, comparator_power_down;
	logic        positive_from_mux, negative_from_internal, comparator_irq, capture_input, up;
	logic [2:0]  negative_ref_code;
	logic [7:0]  ofs [4];
	logic [7:0]  rst [4];
	int          seed, n_fail, tests_run, i;

	acc_top acc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .comparator_raw, .converter_enable,
		.converter_channel_select, .reference_selection, .global_irq_enable,
		.irq_vector_ack, .positive_pin_raw, .negative_pin_raw,
		.external_ref_input_enable, .internal_ref_output_enable, .ref_output_is_2v56,
		.current_source_enable, .comparator_power_down, .positive_from_mux,
		.positive_mux_channel, .negative_from_internal, .negative_ref_code,
		.comparator_irq, .capture_input, .positive_pin_digital, .negative_pin_digital);

	// ==================================================
	// clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ==================================================
	// checking and closing
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ==================================================
	// apb master
	task bus(input logic [7:0] a, input logic [31:0] wd, input logic w);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			k++;
			if (k > 20) begin
				n_fail++;
				end_of_test;
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ==================================================
	// expectations
	function logic fl(input logic [1:0] md, input logic rise);
		return md == 2'h0 || (md == 2'h3 && rise) || (md == 2'h2 && !rise);
	endfunction

	function logic [2:0] nref(input logic [1:0] rs, input logic [1:0] tp);
		if (rs == 2'h1) return 3'h1;
		if (rs == 2'h3) return 3'h2 + {1'b0, tp};
		return 3'h0;
	endfunction

	// ==================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, comparator_raw, converter_enable} = '0;
		{converter_channel_select, reference_selection, global_irq_enable} = '0;
		{irq_vector_ack, positive_pin_raw, negative_pin_raw} = '0;
		seed = 32'hF3B630CB;
		n_fail = 0;
		tests_run = 0;
		ofs = '{acc_pkg::OFS_MISC, acc_pkg::OFS_CTLB, acc_pkg::OFS_CSR, acc_pkg::OFS_DID};
		rst = '{acc_pkg::RST_MISC, acc_pkg::RST_CTLB, acc_pkg::RST_CSR, acc_pkg::RST_DID};
		presetn = 1'b0;
		cyc(2);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++) begin
			bus(ofs[i], 32'h0, 1'b0);
			chk("reset value", rd, {24'h0, rst[i]});
		end
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
			bus(acc_pkg::OFS_MISC, d, 1'b1);
			bus(acc_pkg::OFS_MISC, 32'h0, 1'b0);
			chk("misc", rd, d & 32'h07);
			chk("ext ref", external_ref_input_enable, d[2]);
			chk("ref out", internal_ref_output_enable, d[1]);
			chk("isrc", current_source_enable, d[0]);
		end
		bus(8'h10, 32'h0, 1'b1);
		chk("unmapped err", err, 1'b1);
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			converter_enable <= d[8];
			converter_channel_select <= d[13:9];
			bus(acc_pkg::OFS_CTLB, d, 1'b1);
			bus(acc_pkg::OFS_CTLB, 32'h0, 1'b0);
			chk("ctlb", rd, d & 32'hF7);
			up = d[6] & !d[8];
			chk("pos mux", positive_from_mux, up);
			chk("mux chan", positive_mux_channel, up ? d[13:9] : 5'h0);
		end
		for (i = 0; i < 16; i++) begin
			reference_selection <= i[3:2];
			bus(acc_pkg::OFS_CTLB, {26'h0, i[1:0], 4'h0}, 1'b1);
			bus(acc_pkg::OFS_CSR, 32'h40, 1'b1);
			cyc(2);
			chk("neg internal", negative_from_internal, 1'b1);
			chk("neg code", negative_ref_code, nref(i[3:2], i[1:0]));
			chk("ref 2v56", ref_output_is_2v56, i[3:2] == 2'h3);
		end
		bus(acc_pkg::OFS_CSR, 32'h80, 1'b1);
		cyc(2);
		chk("power down", comparator_power_down, 1'b1);
		chk("neg pin sel", negative_from_internal, 1'b0);
		chk("neg none", negative_ref_code, acc_pkg::NREF_NONE);
		// irq enable low while mode or disable change
		for (i = 0; i < 8; i++) begin
			m = i[2:1];
			up = i[0];
			comparator_raw <= !up;
			cyc(5);
			bus(acc_pkg::OFS_CSR, {27'h0, 1'b1, 2'h0, m}, 1'b1);
			comparator_raw <= up;
			cyc(5);
			bus(acc_pkg::OFS_CSR, 32'h0, 1'b0);
			chk("event", rd, {26'h0, up, fl(m, up), 2'h0, m});
		end
		comparator_raw <= 1'b0;
		cyc(5);
		bus(acc_pkg::OFS_CSR, 32'h1B, 1'b1);
		global_irq_enable <= 1'b1;
		comparator_raw <= 1'b1;
		cyc(6);
		chk("irq", comparator_irq, 1'b1);
		global_irq_enable <= 1'b0;
		cyc(2);
		chk("irq gated", comparator_irq, 1'b0);
		bus(acc_pkg::OFS_CSR, 32'h0B, 1'b1);
		bus(acc_pkg::OFS_CSR, 32'h0, 1'b0);
		chk("flag kept", rd[4], 1'b1);
		irq_vector_ack <= 1'b1;
		cyc(1);
		irq_vector_ack <= 1'b0;
		bus(acc_pkg::OFS_CSR, 32'h0, 1'b0);
		chk("flag ack", rd[4], 1'b0);
		bus(acc_pkg::OFS_CSR, 32'h03, 1'b1);
		bus(acc_pkg::OFS_CSR, 32'h02, 1'b1);
		comparator_raw <= 1'b0;
		cyc(5);
		bus(acc_pkg::OFS_CSR, 32'h0, 1'b0);
		chk("flag fall", rd[4], 1'b1);
		bus(acc_pkg::OFS_CSR, 32'h12, 1'b1);
		bus(acc_pkg::OFS_CSR, 32'h0, 1'b0);
		chk("flag w1c", rd[4], 1'b0);
		chk("power up", comparator_power_down, 1'b0);
		// timer capture mask lies outside block
		bus(acc_pkg::OFS_CSR, 32'h04, 1'b1);
		for (i = 0; i < 6; i++) begin
			d = $random(seed);
			comparator_raw <= d[0];
			cyc(5);
			chk("capture", capture_input, d[0]);
		end
		bus(acc_pkg::OFS_CSR, 32'h0, 1'b1);
		comparator_raw <= 1'b1;
		cyc(5);
		chk("no capture", capture_input, 1'b0);
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			positive_pin_raw <= d[8];
			negative_pin_raw <= d[9];
			bus(acc_pkg::OFS_DID, d, 1'b1);
			bus(acc_pkg::OFS_DID, 32'h0, 1'b0);
			chk("did", rd, d & 32'hFF);
			chk("pos pin", positive_pin_digital, d[8] & !d[7]);
			chk("neg pin", negative_pin_digital, d[9] & !d[6]);
		end
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		bus(acc_pkg::OFS_DID, 32'h0, 1'b0);
		chk("did reset", rd, 32'h0);
		end_of_test;
	end
endmodule
